// file: hdl/sce_top.sv
// Multichannel channel enable block: registers, crossing and link timing
// How it works
// [R1] Up to 32 channels each for receive and for transmit, separate registers.
// [R2] Sixteen enabled channels come from partition A, sixteen from partition B.
// [R3] Block-select fields choose each enable register's block, per direction.
// [R4] Receive enable bit n set receives channel n of selected block.
// [R5] Transmit enable bit n set transmits channel n of selected block.
// [R6] Transmit enable bit n clear does not transmit that channel.
// [R7] All four enable registers are read/write and reset to zero.
// [R8] Enables apply only in receive mode 1, or transmit mode non-zero.
// [R9] Eight blocks of sixteen; even blocks partition A, odd partition B.
// [R10] Serial output is undriven for disabled or masked channels and between frames.
// [R11] Symmetric mode uses receive blocks; transmit enables only mask the drive.
// [R12] Enable bit n maps to channel sixteen times block plus n.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
module sce_top
  import sce_pkg::*;
#(
  parameter int unsigned WORD_BITS = 8,
  parameter int unsigned FRAME_CHANS = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SCE_AW-1:0] addr_i,
  input wire logic [SCE_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SCE_DW-1:0] rdata_o,
  input wire logic link_clk_i,
  input wire logic frame_sync_i,
  input wire logic tx_bit_i,
  output logic [SCE_CH_W-1:0] chan_o,
  output logic rx_take_o,
  output logic tx_load_o,
  output logic serial_tx_out_o,
  output logic serial_tx_oe_o
);

  // Elaboration checks
  initial
  begin
    if (WORD_BITS < 1 || WORD_BITS > 32) $error("sce_top: WORD_BITS out of range");
    if (FRAME_CHANS < 1 || FRAME_CHANS > SCE_CHANS) $error("sce_top: FRAME_CHANS out of range");
  end

  localparam logic [4:0] WORD_LAST = 5'(WORD_BITS - 1);
  localparam logic [SCE_CH_W-1:0] CHAN_LAST = SCE_CH_W'(FRAME_CHANS - 1);

  // ---------------- register side, clk_i ----------------
  logic [SCE_DW-1:0] rx_chan_enable_part_a_q;
  logic [SCE_DW-1:0] rx_chan_enable_part_a_d;
  logic [SCE_DW-1:0] rx_chan_enable_part_b_q;
  logic [SCE_DW-1:0] rx_chan_enable_part_b_d;
  logic [SCE_DW-1:0] tx_chan_enable_part_a_q;
  logic [SCE_DW-1:0] tx_chan_enable_part_a_d;
  logic [SCE_DW-1:0] tx_chan_enable_part_b_q;
  logic [SCE_DW-1:0] tx_chan_enable_part_b_d;
  logic [SCE_CTRL_W-1:0] multichannel_control_q;
  logic [SCE_CTRL_W-1:0] multichannel_control_d;
  logic [SCE_DW-1:0] rdata_q;
  logic [SCE_DW-1:0] rdata_d;
  sce_cfg_t live_cfg;
  sce_cfg_t shadow_q;
  sce_cfg_t shadow_d;
  logic req_q;
  logic req_d;
  logic ack_s;
  logic pending;

  // Register writes
  always_comb
  begin
    rx_chan_enable_part_a_d = rx_chan_enable_part_a_q;
    rx_chan_enable_part_b_d = rx_chan_enable_part_b_q;
    tx_chan_enable_part_a_d = tx_chan_enable_part_a_q;
    tx_chan_enable_part_b_d = tx_chan_enable_part_b_q;
    multichannel_control_d = multichannel_control_q;
    if (wr_i)
    begin
      unique case (addr_i)
        SCE_OFF_RX_A: rx_chan_enable_part_a_d = wdata_i; // R7
        SCE_OFF_RX_B: rx_chan_enable_part_b_d = wdata_i; // R7
        SCE_OFF_TX_A: tx_chan_enable_part_a_d = wdata_i; // R7
        SCE_OFF_TX_B: tx_chan_enable_part_b_d = wdata_i; // R7
        SCE_OFF_CTRL: multichannel_control_d = wdata_i[SCE_CTRL_W-1:0];
        default: ;
      endcase
    end
    if (rst_i)
    begin
      rx_chan_enable_part_a_d = SCE_EN_RST; // R7
      rx_chan_enable_part_b_d = SCE_EN_RST;
      tx_chan_enable_part_a_d = SCE_EN_RST;
      tx_chan_enable_part_b_d = SCE_EN_RST;
      multichannel_control_d = SCE_CTRL_RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rx_chan_enable_part_a_q <= rx_chan_enable_part_a_d;
    rx_chan_enable_part_b_q <= rx_chan_enable_part_b_d;
    tx_chan_enable_part_a_q <= tx_chan_enable_part_a_d;
    tx_chan_enable_part_b_q <= tx_chan_enable_part_b_d;
    multichannel_control_q <= multichannel_control_d;
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    rdata_d = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        SCE_OFF_RX_A: rdata_d = rx_chan_enable_part_a_q;
        SCE_OFF_RX_B: rdata_d = rx_chan_enable_part_b_q;
        SCE_OFF_TX_A: rdata_d = tx_chan_enable_part_a_q;
        SCE_OFF_TX_B: rdata_d = tx_chan_enable_part_b_q;
        SCE_OFF_CTRL: rdata_d = {5'h00, multichannel_control_q};
        SCE_OFF_STAT: rdata_d[SCE_F_PEND] = pending;
        default: rdata_d = '0;
      endcase
    end
    if (rst_i)
    begin
      rdata_d = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rdata_q <= rdata_d;
  end

  assign rdata_o = rdata_q;

  // Live configuration as software sees it
  always_comb
  begin
    live_cfg.rx_mode = multichannel_control_q[SCE_F_RXM];
    live_cfg.tx_mode = multichannel_control_q[SCE_F_TXM +: 2];
    live_cfg.rx_blk_a = multichannel_control_q[SCE_F_RBA +: 2];
    live_cfg.rx_blk_b = multichannel_control_q[SCE_F_RBB +: 2];
    live_cfg.tx_blk_a = multichannel_control_q[SCE_F_TBA +: 2];
    live_cfg.tx_blk_b = multichannel_control_q[SCE_F_TBB +: 2];
    live_cfg.rx_en_a = rx_chan_enable_part_a_q; // R1
    live_cfg.rx_en_b = rx_chan_enable_part_b_q;
    live_cfg.tx_en_a = tx_chan_enable_part_a_q;
    live_cfg.tx_en_b = tx_chan_enable_part_b_q;
  end

  // Toggle handshake: shadow frozen while a transfer is pending
  assign pending = req_q ^ ack_s;

  always_comb
  begin
    shadow_d = shadow_q;
    req_d = req_q;
    if (!pending && shadow_q != live_cfg)
    begin
      shadow_d = live_cfg;
      req_d = ~req_q;
    end
    if (rst_i)
    begin
      shadow_d = '0;
      req_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    shadow_q <= shadow_d;
    req_q <= req_d;
  end

  // ---------------- link side, link_clk_i ----------------
  logic lrst;
  logic req_s;
  logic ack_q;
  logic ack_d;
  sce_cfg_t cfg_q;
  sce_cfg_t cfg_d;
  logic fs_q;
  logic fs_d;
  logic active_q;
  logic active_d;
  logic [SCE_CH_W-1:0] chan_q;
  logic [SCE_CH_W-1:0] chan_d;
  logic [4:0] bit_q;
  logic [4:0] bit_d;
  logic txd_q;
  logic txd_d;
  logic oe_q;
  logic oe_d;

  // Software reset and request toggle into the link domain
  sce_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(lrst)
  );

  sce_sync #(.WIDTH(1)) u_req_sync (
    .clk_i(link_clk_i),
    .rst_i(lrst),
    .d_i(req_q),
    .q_o(req_s)
  );

  // Acknowledge back into the register domain
  sce_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(ack_q),
    .q_o(ack_s)
  );

  // Take the stable shadow when a new request arrives
  always_comb
  begin
    cfg_d = cfg_q;
    ack_d = ack_q;
    if (req_s != ack_q)
    begin
      cfg_d = shadow_q;
      ack_d = req_s;
    end
    if (lrst)
    begin
      cfg_d = '0;
      ack_d = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    cfg_q <= cfg_d;
    ack_q <= ack_d;
  end

  // Frame timing: channel and bit counters, idle between frames
  always_comb
  begin
    fs_d = frame_sync_i;
    active_d = active_q;
    chan_d = chan_q;
    bit_d = bit_q;
    if (fs_q)
    begin
      active_d = 1'b1;
      chan_d = '0;
      bit_d = '0;
    end
    else if (active_q)
    begin
      bit_d = bit_q + 5'h01;
      if (bit_q == WORD_LAST)
      begin
        bit_d = '0;
        if (chan_q == CHAN_LAST)
        begin
          active_d = 1'b0; // R10
        end
        else
        begin
          chan_d = chan_q + 7'h01; // R9 R12
        end
      end
    end
    if (lrst)
    begin
      fs_d = 1'b0;
      active_d = 1'b0;
      chan_d = '0;
      bit_d = '0;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    fs_q <= fs_d;
    active_q <= active_d;
    chan_q <= chan_d;
    bit_q <= bit_d;
  end

  // Channel decoder
  sce_dec_if u_if ();

  assign u_if.cfg = cfg_q;
  assign u_if.chan = chan_q;
  assign u_if.active = active_q;

  sce_decode u_dec (
    .d(u_if.dec)
  );

  // Serial output and its enable, registered
  always_comb
  begin
    txd_d = tx_bit_i & u_if.tx_drive;
    oe_d = u_if.tx_drive; // R10 R6
    if (lrst)
    begin
      txd_d = 1'b0;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    txd_q <= txd_d;
    oe_q <= oe_d;
  end

  assign chan_o = chan_q;
  assign rx_take_o = u_if.rx_take;
  assign tx_load_o = u_if.tx_load;
  assign serial_tx_out_o = txd_q;
  assign serial_tx_oe_o = oe_q;

  // ---------------- checks ----------------
  logic sel_rx;
  logic sel_tx;
  assign sel_rx = sce_pick(chan_q, cfg_q.rx_blk_a, cfg_q.rx_blk_b,
                           cfg_q.rx_en_a, cfg_q.rx_en_b);
  assign sel_tx = sce_pick(chan_q, cfg_q.tx_blk_a, cfg_q.tx_blk_b,
                           cfg_q.tx_en_a, cfg_q.tx_en_b);

  chk_reg_reset: assert property (@(posedge clk_i) rst_i |=> // R7
    rx_chan_enable_part_a_q == SCE_EN_RST && rx_chan_enable_part_b_q == SCE_EN_RST
    && tx_chan_enable_part_a_q == SCE_EN_RST && tx_chan_enable_part_b_q == SCE_EN_RST)
    else $error("enable registers not cleared by reset");

  chk_reg_readback: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    rd_i && addr_i == SCE_OFF_TX_B |=> rdata_o == $past(tx_chan_enable_part_b_q))
    else $error("enable register read back wrong");

  chk_rx_bypass: assert property (@(posedge link_clk_i) disable iff (lrst) // R8
    active_q && !cfg_q.rx_mode |-> rx_take_o)
    else $error("receive skipped outside multichannel mode");

  chk_rx_bit_sel: assert property (@(posedge link_clk_i) disable iff (lrst) // R4
    active_q && cfg_q.rx_mode |-> rx_take_o == sel_rx)
    else $error("receive enable bit not followed");

  chk_rx_partition: assert property (@(posedge link_clk_i) disable iff (lrst) // R2
    rx_take_o && cfg_q.rx_mode |-> chan_q[SCE_CH_W-1:SCE_BLK_LSB] == {cfg_q.rx_blk_a, 1'b0}
    || chan_q[SCE_CH_W-1:SCE_BLK_LSB] == {cfg_q.rx_blk_b, 1'b1})
    else $error("receive outside selected blocks");

  chk_tx_sel_mode: assert property (@(posedge link_clk_i) disable iff (lrst) // R5
    active_q && cfg_q.tx_mode == SCE_TXM_SEL |-> tx_load_o == sel_tx)
    else $error("transmit enable bit not followed");

  chk_tx_skip_oe: assert property (@(posedge link_clk_i) disable iff (lrst) // R6
    active_q && cfg_q.tx_mode != SCE_TXM_ALL && cfg_q.tx_mode != SCE_TXM_SYM && !sel_tx
    |=> !serial_tx_oe_o)
    else $error("disabled channel driven");

  chk_sym_load: assert property (@(posedge link_clk_i) disable iff (lrst) // R11
    active_q && cfg_q.tx_mode == SCE_TXM_SYM |-> tx_load_o == sel_rx)
    else $error("symmetric mode ignores receive selection");

  chk_idle_hiz: assert property (@(posedge link_clk_i) disable iff (lrst) // R10
    !active_q ##1 !active_q |-> !serial_tx_oe_o && !tx_load_o)
    else $error("output driven between frames");

  chk_oe_drive: assert property (@(posedge link_clk_i) disable iff (lrst) // R10
    serial_tx_oe_o |-> $past(tx_load_o))
    else $error("drive without a transmitted channel");

  cov_sym_drive: cover property (@(posedge link_clk_i) disable iff (lrst)
    cfg_q.tx_mode == SCE_TXM_SYM && serial_tx_oe_o);
  cov_rx_part_b: cover property (@(posedge link_clk_i) disable iff (lrst)
    cfg_q.rx_mode && rx_take_o && chan_q[SCE_BLK_LSB]);
  cov_update: cover property (@(posedge clk_i) disable iff (rst_i)
    pending ##1 !pending);
endmodule

// file: include/sce_pkg.sv
// Shared constants, types and channel decode for the channel enable block
package sce_pkg;

  // Register port geometry
  localparam int unsigned SCE_AW = 4;
  localparam int unsigned SCE_DW = 16;

  // Register offsets on the plain register port
  localparam logic [SCE_AW-1:0] SCE_OFF_RX_A = 4'h0;
  localparam logic [SCE_AW-1:0] SCE_OFF_RX_B = 4'h1;
  localparam logic [SCE_AW-1:0] SCE_OFF_TX_A = 4'h2;
  localparam logic [SCE_AW-1:0] SCE_OFF_TX_B = 4'h3;
  localparam logic [SCE_AW-1:0] SCE_OFF_CTRL = 4'h4;
  localparam logic [SCE_AW-1:0] SCE_OFF_STAT = 4'h5;

  // Field positions in multichannel_control
  localparam int unsigned SCE_F_RXM = 0;
  localparam int unsigned SCE_F_TXM = 1;
  localparam int unsigned SCE_F_RBA = 3;
  localparam int unsigned SCE_F_RBB = 5;
  localparam int unsigned SCE_F_TBA = 7;
  localparam int unsigned SCE_F_TBB = 9;
  localparam int unsigned SCE_CTRL_W = 11;
  // Field position in the status register
  localparam int unsigned SCE_F_PEND = 0;

  // Reset values
  localparam logic [SCE_DW-1:0] SCE_EN_RST = 16'h0000;
  localparam logic [SCE_CTRL_W-1:0] SCE_CTRL_RST = 11'h000;

  // Channel number layout: block index above, channel in block below
  localparam int unsigned SCE_CH_W = 7;
  localparam int unsigned SCE_BLK_LSB = 4;
  localparam int unsigned SCE_CHANS = 128;

  // Transmit multichannel mode encodings
  localparam logic [1:0] SCE_TXM_ALL = 2'h0;
  localparam logic [1:0] SCE_TXM_SEL = 2'h1;
  localparam logic [1:0] SCE_TXM_MASK = 2'h2;
  localparam logic [1:0] SCE_TXM_SYM = 2'h3;

  typedef struct packed {
    logic rx_mode;
    logic [1:0] tx_mode;
    logic [1:0] rx_blk_a;
    logic [1:0] rx_blk_b;
    logic [1:0] tx_blk_a;
    logic [1:0] tx_blk_b;
    logic [SCE_DW-1:0] rx_en_a;
    logic [SCE_DW-1:0] rx_en_b;
    logic [SCE_DW-1:0] tx_en_a;
    logic [SCE_DW-1:0] tx_en_b;
  } sce_cfg_t;

  // Enable of one absolute channel: even block from A, odd block from B
  function automatic logic sce_pick(input logic [SCE_CH_W-1:0] chan,
                                    input logic [1:0] blk_a,
                                    input logic [1:0] blk_b,
                                    input logic [SCE_DW-1:0] en_a,
                                    input logic [SCE_DW-1:0] en_b);
    logic [SCE_CH_W-SCE_BLK_LSB-1:0] blk;
    logic [SCE_BLK_LSB-1:0] idx;
    blk = chan[SCE_CH_W-1:SCE_BLK_LSB]; // R2 R9
    idx = chan[SCE_BLK_LSB-1:0];
    return ((blk == {blk_a, 1'b0}) & en_a[idx]) | ((blk == {blk_b, 1'b1}) & en_b[idx]);
  endfunction

endpackage

// file: include/sce_dec_if.sv
// Interface between the link logic and the channel decoder
`timescale 1ns/100ps
interface sce_dec_if;
  import sce_pkg::*;
  sce_cfg_t cfg;
  logic [SCE_CH_W-1:0] chan;
  logic active;
  logic rx_take;
  logic tx_load;
  logic tx_drive;

  modport ctl (output cfg, output chan, output active,
               input rx_take, input tx_load, input tx_drive);
  modport dec (input cfg, input chan, input active,
               output rx_take, output tx_load, output tx_drive);
endinterface

// file: hdl/sce_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module sce_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  initial
  begin
    if (WIDTH < 1) $error("sce_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_comb
  begin
    meta_d = rst_i ? '0 : d_i;
    sync_d = rst_i ? '0 : meta_q;
  end

  always_ff @(posedge clk_i)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign q_o = sync_q;
endmodule

// file: hdl/sce_decode.sv
// Per-channel receive, transmit and drive decision
`timescale 1ns/100ps
module sce_decode
  import sce_pkg::*;
(
  sce_dec_if.dec d
);
  logic rx_sel;
  logic tx_sel;
  logic sym_sel;
  logic sym_mask;

  // Channel selections from both partitions
  always_comb
  begin
    rx_sel = sce_pick(d.chan, d.cfg.rx_blk_a, d.cfg.rx_blk_b,
                      d.cfg.rx_en_a, d.cfg.rx_en_b); // R3 R4 R12
    tx_sel = sce_pick(d.chan, d.cfg.tx_blk_a, d.cfg.tx_blk_b,
                      d.cfg.tx_en_a, d.cfg.tx_en_b); // R3 R5 R12
    sym_sel = rx_sel;
    sym_mask = sce_pick(d.chan, d.cfg.rx_blk_a, d.cfg.rx_blk_b,
                        d.cfg.tx_en_a, d.cfg.tx_en_b); // R11
  end

  // Receive: all channels unless multichannel mode
  always_comb
  begin
    d.rx_take = d.active & (d.cfg.rx_mode ? rx_sel : 1'b1); // R8 R4
  end

  // Transmit per mode; drive never outside a load
  always_comb
  begin
    d.tx_load = 1'b0;
    d.tx_drive = 1'b0;
    unique case (d.cfg.tx_mode)
      SCE_TXM_ALL:
      begin
        d.tx_load = d.active; // R8
        d.tx_drive = d.active;
      end
      SCE_TXM_SEL:
      begin
        d.tx_load = d.active & tx_sel; // R5 R6
        d.tx_drive = d.active & tx_sel;
      end
      SCE_TXM_MASK:
      begin
        d.tx_load = d.active;
        d.tx_drive = d.active & tx_sel; // R6 R10
      end
      SCE_TXM_SYM:
      begin
        d.tx_load = d.active & sym_sel; // R11
        d.tx_drive = d.active & sym_sel & sym_mask; // R11 R10
      end
    endcase
  end
endmodule

// file: tb/sce_link_model.sv
// Far-side frame source and line monitor for the channel enable block
`timescale 1ns/100ps
module sce_link_model
  import sce_pkg::*;
#(
  parameter int unsigned WORD_BITS = 2,
  parameter int unsigned FRAME_CHANS = 128
) (
  output logic link_clk_o,
  output logic frame_sync_o,
  output logic tx_bit_o,
  input wire logic [SCE_CH_W-1:0] chan_i,
  input wire logic rx_take_i,
  input wire logic tx_load_i,
  input wire logic tx_out_i,
  input wire logic tx_oe_i
);
  logic [SCE_CHANS-1:0] rx_v;
  logic [SCE_CHANS-1:0] tx_v;
  logic [SCE_CHANS-1:0] oe_v;
  int err_cnt;

  // Idle levels at time zero
  initial
  begin
    link_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    tx_bit_o = 1'b0;
    err_cnt = 0;
  end

  // One link cycle; outputs recorded at the falling edge when in a frame
  task automatic tick(input int i);
    int ch;
    link_clk_o = 1'b1;
    #62.5 link_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    if (i >= 0 && i < WORD_BITS * FRAME_CHANS)
    begin
      ch = i / WORD_BITS;
      if (chan_i !== SCE_CH_W'(ch)) err_cnt++;
      rx_v[ch] = rx_take_i;
      tx_v[ch] = tx_load_i;
      if (i % WORD_BITS == WORD_BITS - 1) oe_v[ch] = tx_oe_i;
    end
    if (i >= 0 && tx_oe_i !== 1'b1 && tx_out_i !== 1'b0) err_cnt++;
    // Driven line carries the bit offered at this cycle's rising edge
    if (i >= 0 && tx_oe_i === 1'b1 && tx_out_i !== tx_bit_o) err_cnt++;
    if (i == WORD_BITS * FRAME_CHANS + 3 && tx_oe_i !== 1'b0) err_cnt++;
    // Data line changes every cycle so a stale value never passes
    tx_bit_o = ~tx_bit_o;
    #62.5;
  endtask

  // Clock cycles with no frame, for reset and config crossing
  task automatic idle(input int n);
    repeat (n) tick(-1);
  endtask

  // One full frame plus a short idle tail, clock stopped afterwards
  task automatic frame();
    #7 frame_sync_o = 1'b1;
    for (int i = -1; i < int'(WORD_BITS * FRAME_CHANS) + 4; i++) tick(i);
  endtask
endmodule

// file: tb/sce_top_tb_top.sv
// Self-checking bench for the channel enable block
`timescale 1ns/100ps
module sce_top_tb_top;
  import sce_pkg::*;
  localparam int unsigned WB = 2;
  localparam int unsigned FC = 128;
  typedef struct packed {
    logic rxm;
    logic [1:0] txm, rba, rbb, tba, tbb;
    logic [15:0] ra, rb, ta, tb;
  } sce_tb_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [SCE_AW-1:0] addr_i = 4'h0;
  logic [SCE_DW-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire logic [SCE_DW-1:0] rdata_o;
  wire logic link_clk, frame_sync, tx_bit, rx_take, tx_load, tx_out, tx_oe;
  wire logic [SCE_CH_W-1:0] chan;
  int error_cnt = 0;
  int compares = 0;
  sce_tb_row_t rows [4];

  sce_top #(.WORD_BITS(WB), .FRAME_CHANS(FC)) u_sce_top (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .link_clk_i(link_clk), .frame_sync_i(frame_sync),
    .tx_bit_i(tx_bit), .chan_o(chan), .rx_take_o(rx_take), .tx_load_o(tx_load),
    .serial_tx_out_o(tx_out), .serial_tx_oe_o(tx_oe));

  sce_link_model #(.WORD_BITS(WB), .FRAME_CHANS(FC)) u_sce_link_model (
    .link_clk_o(link_clk), .frame_sync_o(frame_sync), .tx_bit_o(tx_bit),
    .chan_i(chan), .rx_take_i(rx_take), .tx_load_i(tx_load), .tx_out_i(tx_out),
    .tx_oe_i(tx_oe));

  // Register clock, 100 ns period
  always #50 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare of register data
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare of per-channel vectors
  task automatic cmp128(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write
  task automatic reg_wr(input logic [SCE_AW-1:0] a, input logic [SCE_DW-1:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // One-cycle read, data taken in the following cycle
  task automatic reg_rd(input logic [SCE_AW-1:0] a, output logic [SCE_DW-1:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Read and compare
  task automatic chk_rd(input logic [SCE_AW-1:0] a, input logic [15:0] exp, input string what);
    logic [SCE_DW-1:0] d;
    reg_rd(a, d);
    cmp16(what, exp, d);
  endtask

  // Enable of one channel: block 2*ba from A, block 2*bb+1 from B
  function automatic logic exp_pick(input int ch, input logic [1:0] ba, input logic [1:0] bb,
                                    input logic [15:0] ea, input logic [15:0] eb);
    if (ch / 16 == 2 * ba) return ea[ch % 16];
    if (ch / 16 == 2 * bb + 1) return eb[ch % 16];
    return 1'b0;
  endfunction

  // Program one setting, let it cross, run a frame and check every channel
  task automatic run_case(input sce_tb_row_t c);
    logic [SCE_DW-1:0] ctrl;
    logic [SCE_DW-1:0] d;
    logic [127:0] ex_rx, ex_tx, ex_oe;
    int done;
    ctrl = 16'h0000;
    ctrl[SCE_F_RXM] = c.rxm;
    ctrl[SCE_F_TXM +: 2] = c.txm;
    ctrl[SCE_F_RBA +: 2] = c.rba;
    ctrl[SCE_F_RBB +: 2] = c.rbb;
    ctrl[SCE_F_TBA +: 2] = c.tba;
    ctrl[SCE_F_TBB +: 2] = c.tbb;
    reg_wr(SCE_OFF_RX_A, c.ra);
    reg_wr(SCE_OFF_RX_B, c.rb);
    reg_wr(SCE_OFF_TX_A, c.ta);
    reg_wr(SCE_OFF_TX_B, c.tb);
    reg_wr(SCE_OFF_CTRL, ctrl);
    done = 0;
    for (int k = 0; k < 8 && done == 0; k++)
    begin
      u_sce_link_model.idle(8);
      reg_rd(SCE_OFF_STAT, d);
      if (d[SCE_F_PEND] === 1'b0) done = 1;
    end
    cmp16("update pending", 16'h0000, {15'h0000, d[SCE_F_PEND]});
    if (done == 0) results();
    for (int ch = 0; ch < int'(FC); ch++)
    begin
      ex_rx[ch] = c.rxm ? exp_pick(ch, c.rba, c.rbb, c.ra, c.rb) : 1'b1;
      ex_tx[ch] = (c.txm == SCE_TXM_SEL) ? exp_pick(ch, c.tba, c.tbb, c.ta, c.tb) :
                  (c.txm == SCE_TXM_SYM) ? exp_pick(ch, c.rba, c.rbb, c.ra, c.rb) : 1'b1;
      ex_oe[ch] = (c.txm == SCE_TXM_ALL) ? 1'b1 :
                  (c.txm == SCE_TXM_SYM) ? (exp_pick(ch, c.rba, c.rbb, c.ra, c.rb) &
                                            exp_pick(ch, c.rba, c.rbb, c.ta, c.tb)) :
                  exp_pick(ch, c.tba, c.tbb, c.ta, c.tb);
    end
    u_sce_link_model.frame();
    cmp128("rx take", ex_rx, u_sce_link_model.rx_v);
    cmp128("tx load", ex_tx, u_sce_link_model.tx_v);
    cmp128("tx drive", ex_oe, u_sce_link_model.oe_v);
    cmp16("line monitor", 16'h0000, u_sce_link_model.err_cnt[15:0]);
  endtask

  // Cut a hang short
  initial
  begin
    #2000000;
    error_cnt++;
    results();
  end

  // Main sequence
  initial
  begin
    rows[0] = '{1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 16'h8001, 16'h7FFE, 16'h1111, 16'h2222};
    rows[1] = '{1'b1, 2'h1, 2'h0, 2'h3, 2'h3, 2'h0, 16'h8001, 16'h7FFE, 16'hA5C3, 16'h0FF0};
    rows[2] = '{1'b1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 16'hFFFF, 16'h0000, 16'h1234, 16'h8000};
    rows[3] = '{1'b1, 2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 16'hF0F0, 16'h00FF, 16'h3033, 16'h000F};
    // Reset with the link clock running long enough for its side
    fork
      #10 u_sce_link_model.idle(6);
      begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
      end
    join
    chk_rd(SCE_OFF_RX_A, SCE_EN_RST, "rx a reset");
    chk_rd(SCE_OFF_RX_B, SCE_EN_RST, "rx b reset");
    chk_rd(SCE_OFF_TX_A, SCE_EN_RST, "tx a reset");
    chk_rd(SCE_OFF_TX_B, SCE_EN_RST, "tx b reset");
    chk_rd(SCE_OFF_CTRL, 16'h0000, "control reset");
    chk_rd(4'hF, 16'h0000, "unmapped read");
    // Writes one idle cycle apart, every bit set and cleared somewhere
    reg_wr(SCE_OFF_RX_A, 16'hFFFF);
    reg_wr(SCE_OFF_RX_B, 16'h5AA5);
    reg_wr(SCE_OFF_TX_A, 16'hA55A);
    reg_wr(SCE_OFF_TX_B, 16'h0001);
    reg_wr(SCE_OFF_CTRL, 16'hFFFF);
    reg_wr(4'hE, 16'hFFFF);
    chk_rd(SCE_OFF_RX_A, 16'hFFFF, "rx a readback");
    chk_rd(SCE_OFF_RX_B, 16'h5AA5, "rx b readback");
    chk_rd(SCE_OFF_TX_A, 16'hA55A, "tx a readback");
    chk_rd(SCE_OFF_TX_B, 16'h0001, "tx b readback");
    chk_rd(SCE_OFF_CTRL, 16'h07FF, "control readback");
    chk_rd(4'hE, 16'h0000, "unmapped after write");
    // Every transmit mode, receive mode off and on
    for (int k = 0; k < 4; k++) run_case(rows[k]);
    // Mid-run reset: registers and link configuration back to defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    fork
      #10 u_sce_link_model.idle(6);
      begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
      end
    join
    chk_rd(SCE_OFF_RX_A, SCE_EN_RST, "rx a after reset");
    chk_rd(SCE_OFF_RX_B, SCE_EN_RST, "rx b after reset");
    chk_rd(SCE_OFF_TX_A, SCE_EN_RST, "tx a after reset");
    chk_rd(SCE_OFF_TX_B, SCE_EN_RST, "tx b after reset");
    chk_rd(SCE_OFF_CTRL, 16'h0000, "control after reset");
    // Default settings, rewritten as zeros, must reach the link side
    run_case('0);
    results();
  end
endmodule
